// ### hw/pin_config_consts.vh
// Register map, field positions and mode codes of the pin configuration bank.
`ifndef PIN_CONFIG_CONSTS_VH
`define PIN_CONFIG_CONSTS_VH

// ****************************************************************************
// Register word indices (byte address is the index times four, one aligned word each)
// ****************************************************************************
`define IDX_PIN3_CONFIG      8'h1f
`define IDX_PIN5_PIN6_CONFIG 8'h20
`define IDX_PIN7_PIN8_CONFIG 8'h21
`define IDX_PORT_SELECT      8'h30
`define IDX_PIN_STATUS       8'h31
`define ADDR_WIDTH           12
`define REG_RESET            8'h00

// ****************************************************************************
// Per-pin nibble layout
// ****************************************************************************
`define FLD_ENABLE           0
`define FLD_DIRECTION        1
`define FLD_REMOTE           2
`define FLD_LEVEL            3

// ****************************************************************************
// Pad mode codes, {direction, enable}
// ****************************************************************************
`define MODE_FUNC_OUT        2'b00
`define MODE_PIN_OUT         2'b01
`define MODE_TRISTATE        2'b10
`define MODE_PIN_IN          2'b11

`endif

// ### hw/pad_mode_decode.v
// Decoder that turns one pin's configuration nibble into pad controls.
`default_nettype none
`include "pin_config_consts.vh"

module pad_mode_decode (
    input  wire [3:0] i_cfg,
    input  wire       i_remote_level,
    input  wire       i_func_level,
    output reg        o_drive,
    output reg        o_level
);

    wire [1:0] mode;

    assign mode = {i_cfg[`FLD_DIRECTION], i_cfg[`FLD_ENABLE]};

    always @* begin
        o_drive = 1'b0;
        o_level = 1'b0;
        if (i_cfg[`FLD_REMOTE]) begin
            o_drive = 1'b1;
            o_level = i_remote_level;
        end else begin
            case (mode)
                `MODE_FUNC_OUT: begin
                    o_drive = 1'b1;
                    o_level = i_func_level;
                end
                `MODE_PIN_OUT: begin
                    o_drive = 1'b1;
                    o_level = i_cfg[`FLD_LEVEL];
                end
                `MODE_TRISTATE: begin
                    o_drive = 1'b0;
                end
                default: begin
                    o_drive = 1'b0;
                end
            endcase
        end
    end

endmodule
`default_nettype wire

// ### hw/pin_config_bank.v
// APB register bank and pad control for pins 3 (both ports), 5, 6, 7 and 8.
//
// Overview of operation
// - Port select steers pin 3 register
// - Upper nibble of pin 3 reserved, writable
// - Local level driven only pin-mode output
// - Remote enable drives remote value out
// - Direction/enable pair selects pad mode
// - High nibble higher pin, low nibble lower
`default_nettype none
`include "pin_config_consts.vh"

module pin_config_bank #(
    parameter NUM_PADS = 6
) (
    input  wire                   i_ref_clk,
    input  wire                   i_rst,
    input  wire                   psel,
    input  wire                   penable,
    input  wire                   pwrite,
    input  wire [`ADDR_WIDTH-1:0] paddr,
    input  wire [31:0]            pwdata,
    input  wire [3:0]             pstrb,
    output reg  [31:0]            prdata,
    output reg                    pready,
    output reg                    pslverr,
    input  wire [NUM_PADS-1:0]    i_pad_in,
    input  wire [NUM_PADS-1:0]    i_remote_level,
    input  wire [NUM_PADS-1:0]    i_func_level,
    output reg  [NUM_PADS-1:0]    o_pad_out,
    output reg  [NUM_PADS-1:0]    o_pad_oe
);

    // Pad order: 0 first_port_pin3, 1 second_port_pin3, 2 pin_five,
    // 3 pin_six, 4 pin_seven, 5 pin_eight.

    // ************************************************************************
    // Configuration state
    // ************************************************************************
    reg  [7:0]          pin3_first;
    reg  [7:0]          pin3_second;
    reg  [7:0]          pin5_pin6_config;
    reg  [7:0]          pin7_pin8_config;
    reg                 second_port_select;
    reg  [NUM_PADS-1:0] pad_meta;
    reg  [NUM_PADS-1:0] pad_sync;
    reg  [NUM_PADS-1:0] remote_meta;
    reg  [NUM_PADS-1:0] remote_sync;

    wire                 access;
    wire                 wr_en;
    wire [`ADDR_WIDTH-3:0] word_addr;
    wire                 addr_hit;
    wire [7:0]           pin3_view;
    wire [4*NUM_PADS-1:0] cfg_bus;
    wire [NUM_PADS-1:0]  next_pad_out;
    wire [NUM_PADS-1:0]  next_pad_oe;

    assign access    = psel & penable & pready;
    assign wr_en     = access & pwrite & pstrb[0];
    assign word_addr = paddr[`ADDR_WIDTH-1:2];
    assign addr_hit  = (word_addr == `IDX_PIN3_CONFIG) || (word_addr == `IDX_PIN5_PIN6_CONFIG) ||
                       (word_addr == `IDX_PIN7_PIN8_CONFIG) || (word_addr == `IDX_PORT_SELECT) ||
                       (word_addr == `IDX_PIN_STATUS);

    assign pin3_view = second_port_select ? pin3_second : pin3_first;

    assign cfg_bus = {pin7_pin8_config[7:4], pin7_pin8_config[3:0],
                      pin5_pin6_config[7:4], pin5_pin6_config[3:0],
                      pin3_second[3:0], pin3_first[3:0]};

    // ************************************************************************
    // Input synchronisers
    // ************************************************************************
    // Pad and link levels come from outside this clock domain.
    always @(posedge i_ref_clk) begin
        if (i_rst) begin
            pad_meta    <= {NUM_PADS{1'b0}};
            pad_sync    <= {NUM_PADS{1'b0}};
            remote_meta <= {NUM_PADS{1'b0}};
            remote_sync <= {NUM_PADS{1'b0}};
        end else begin
            pad_meta    <= i_pad_in;
            pad_sync    <= pad_meta;
            remote_meta <= i_remote_level;
            remote_sync <= remote_meta;
        end
    end

    // ************************************************************************
    // APB register access
    // ************************************************************************
    always @(posedge i_ref_clk) begin
        if (i_rst) begin
            pin3_first         <= `REG_RESET;
            pin3_second        <= `REG_RESET;
            pin5_pin6_config   <= `REG_RESET;
            pin7_pin8_config   <= `REG_RESET;
            second_port_select <= 1'b0;
            pready             <= 1'b0;
            pslverr            <= 1'b0;
            prdata             <= 32'h0000_0000;
        end else begin
            // One wait state: pready answers in the second access cycle.
            pready  <= psel & penable & ~pready;
            pslverr <= psel & penable & ~pready & ~addr_hit;
            if (wr_en) begin
                case (word_addr)
                    `IDX_PIN3_CONFIG: begin
                        if (second_port_select) begin
                            pin3_second <= pwdata[7:0];
                        end else begin
                            pin3_first <= pwdata[7:0];
                        end
                    end
                    `IDX_PIN5_PIN6_CONFIG: begin
                        pin5_pin6_config <= pwdata[7:0];
                    end
                    `IDX_PIN7_PIN8_CONFIG: begin
                        pin7_pin8_config <= pwdata[7:0];
                    end
                    `IDX_PORT_SELECT: begin
                        second_port_select <= pwdata[0];
                    end
                    default: begin
                        second_port_select <= second_port_select;
                    end
                endcase
            end
            if (psel & penable & ~pready & ~pwrite) begin
                case (word_addr)
                    `IDX_PIN3_CONFIG:      prdata <= {24'h00_0000, pin3_view};
                    `IDX_PIN5_PIN6_CONFIG: prdata <= {24'h00_0000, pin5_pin6_config};
                    `IDX_PIN7_PIN8_CONFIG: prdata <= {24'h00_0000, pin7_pin8_config};
                    `IDX_PORT_SELECT:      prdata <= {31'h0000_0000, second_port_select};
                    `IDX_PIN_STATUS:       prdata <= {16'h0000, 2'b00, o_pad_oe, 2'b00, pad_sync};
                    default:               prdata <= 32'h0000_0000;
                endcase
            end
        end
    end

    // ************************************************************************
    // Pad decoders
    // ************************************************************************
    genvar g;
    generate
        for (g = 0; g < NUM_PADS; g = g + 1) begin : pad
            pad_mode_decode u_decode (
                .i_cfg          (cfg_bus[4*g+3:4*g]),
                .i_remote_level (remote_sync[g]),
                .i_func_level   (i_func_level[g]),
                .o_drive        (next_pad_oe[g]),
                .o_level        (next_pad_out[g])
            );
        end
    endgenerate

    // Registered pad controls keep the pins glitch free across decode changes.
    always @(posedge i_ref_clk) begin
        if (i_rst) begin
            o_pad_out <= {NUM_PADS{1'b0}};
            o_pad_oe  <= {NUM_PADS{1'b0}};
        end else begin
            o_pad_out <= next_pad_out;
            o_pad_oe  <= next_pad_oe;
        end
    end

endmodule
`default_nettype wire

// ### tb/pin_config_bank_checker.sv
// Port-level assertions for the pin configuration bank.
`default_nettype none
module pin_config_bank_checker (
    input wire logic        i_ref_clk,
    input wire logic        i_rst,
    input wire logic        psel,
    input wire logic        penable,
    input wire logic        pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] prdata,
    input wire logic        pready,
    input wire logic        pslverr,
    input wire logic [5:0]  o_pad_oe
);
    timeunit 1ns;
    timeprecision 1ps;
    default clocking cb @(posedge i_ref_clk); endclocking
    default disable iff (i_rst);
    apb_wait_a: assert property ($rose(penable) && psel |=> pready)
        else $error("no answer after one wait state");
    ready_pulse_a: assert property (pready |=> !pready)
        else $error("ready held longer than one cycle");
    ready_cause_a: assert property (pready |-> psel && penable)
        else $error("ready outside an access phase");
    idle_quiet_a: assert property (!psel |=> !pready)
        else $error("ready without a selected transfer");
    refused_zero_a: assert property (pslverr |-> pready && prdata == 32'h0000_0000)
        else $error("unmapped access returned data");
    upper_zero_a: assert property (pready && !pwrite && paddr != 12'h0c4 |-> prdata[31:8] == 24'h00_0000)
        else $error("read data above the byte not zero");
    // Mode changes come only from a register write, never from pad or link inputs.
    oe_cause_a: assert property ($changed(o_pad_oe) && !$past(i_rst) && !$past(i_rst, 2) && !$past(i_rst, 3)
        |-> $past(pready, 2) && $past(pwrite, 2)) else $error("pad enable changed without a write");
    reset_clear_a: assert property (disable iff (1'b0) i_rst |=> o_pad_oe == 6'h00 && !pready)
        else $error("outputs not cleared by reset");
    cover property (pslverr);
    cover property (pready && pwrite);
    cover property ($fell(o_pad_oe[2]));
endmodule
`default_nettype wire

// ### tb/remote_serializer_model.sv
// Far-side serializer model that forwards pin levels over the link.
`default_nettype none
module remote_serializer_model (
    input  wire logic       i_ref_clk,
    input  wire logic [5:0] i_next_levels,
    output var  logic [5:0] o_remote_level
);
    timeunit 1ns;
    timeprecision 1ps;
    // Levels move only at clock edges, as the decoded link stream would deliver them.
    initial o_remote_level = 6'h00;
    always @(posedge i_ref_clk) o_remote_level <= i_next_levels;
endmodule
`default_nettype wire

// ### tb/pin_config_bank_tb_top.sv
// Self-checking bench for the pin configuration bank.
`default_nettype none
module pin_config_bank_tb_top;
    timeunit 1ns;
    timeprecision 1ps;
    localparam logic [5:0] FUNC = 6'h2a;
    logic        i_ref_clk = 1'b0;
    logic        i_rst = 1'b1;
    logic        psel = 1'b0;
    logic        penable = 1'b0;
    logic        pwrite = 1'b0;
    logic [11:0] paddr = 12'h000;
    logic [31:0] pwdata = 32'h0000_0000;
    logic [31:0] prdata;
    logic        pready;
    logic        pslverr;
    logic [5:0]  o_pad_out;
    logic [5:0]  o_pad_oe;
    logic [5:0]  remote;
    logic [5:0]  next_levels = 6'h00;
    logic [7:0]  rd;
    logic        err;
    int          fail_count = 0;
    int          check_count = 0;
    pin_config_bank u_dut (.i_ref_clk(i_ref_clk), .i_rst(i_rst), .psel(psel), .penable(penable), .pwrite(pwrite),
        .paddr(paddr), .pwdata(pwdata), .pstrb(4'hf), .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .i_pad_in(6'h00), .i_remote_level(remote), .i_func_level(FUNC), .o_pad_out(o_pad_out), .o_pad_oe(o_pad_oe));
    remote_serializer_model u_far (.i_ref_clk(i_ref_clk), .i_next_levels(next_levels), .o_remote_level(remote));
    initial forever #20 i_ref_clk = ~i_ref_clk;
    task automatic check(input logic [31:0] got, input logic [31:0] exp);
        check_count++;
        if (got !== exp) begin
            fail_count++;
            $display("CHECK FAILED at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic apb(input logic wr, input logic [11:0] a, input logic [7:0] d);
        int n;
        psel <= 1'b1;
        pwrite <= wr;
        paddr <= a;
        pwdata <= {24'h00_0000, d};
        @(posedge i_ref_clk);
        penable <= 1'b1;
        n = 0;
        // Look between edges, where the registered answer has settled.
        do begin
            @(negedge i_ref_clk);
            n++;
        end while (pready !== 1'b1 && n < 20);
        rd = prdata[7:0];
        err = pslverr;
        check(n < 20, 1);
        // The rising edge that samples pready high completes the transfer.
        @(posedge i_ref_clk);
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge i_ref_clk);
    endtask
    task automatic t_reset;
        apb(0, 12'h07c, 0);
        check(rd, 0);
        apb(0, 12'h080, 0);
        check(rd, 0);
        apb(0, 12'h084, 0);
        check(rd, 0);
        check({o_pad_oe, o_pad_out}, {6'h3f, FUNC});
    endtask
    task automatic t_modes;
        for (int m = 0; m < 4; m++) begin
            apb(1, 12'h080, 8'h28 | m[7:0]);
            repeat (2) @(posedge i_ref_clk);
            check(o_pad_oe[3:2], {1'b0, ~m[1]});
            if (!m[1]) check(o_pad_out[2], (m == 0) ? FUNC[2] : 1'b1);
        end
        apb(1, 12'h084, 8'h92);
        repeat (2) @(posedge i_ref_clk);
        check({o_pad_oe[5:4], o_pad_out[5]}, 3'b101);
    endtask
    task automatic t_remote;
        apb(1, 12'h080, 8'h07);
        next_levels <= 6'h3f;
        repeat (6) @(posedge i_ref_clk);
        check({o_pad_oe[2], o_pad_out[2]}, 2'b11);
        apb(1, 12'h080, 8'h01);
        repeat (2) @(posedge i_ref_clk);
        check({o_pad_oe[2], o_pad_out[2]}, 2'b10);
    endtask
    task automatic t_port;
        apb(1, 12'h07c, 8'hf1);
        apb(0, 12'h07c, 0);
        check(rd, 8'hf1);
        apb(1, 12'h0c0, 8'h01);
        apb(0, 12'h07c, 0);
        check(rd, 0);
        apb(1, 12'h07c, 8'h0b);
        repeat (2) @(posedge i_ref_clk);
        check({o_pad_oe[1:0], o_pad_out[0]}, 3'b010);
        apb(1, 12'h0c0, 0);
        apb(0, 12'h07c, 0);
        check(rd, 8'hf1);
        apb(0, 12'h088, 0);
        check({err, rd}, 9'h100);
    endtask
    task automatic report_and_stop;
        $display("checks %0d, mismatches %0d", check_count, fail_count);
        if (fail_count == 0 && check_count > 0)
            $display("Simulation passed");
        else
            $display("Simulation failed");
        $finish;
    endtask
    initial begin
        repeat (4) @(posedge i_ref_clk);
        i_rst <= 1'b0;
        @(posedge i_ref_clk);
        t_reset;
        t_modes;
        t_remote;
        t_port;
        report_and_stop;
    end
    // The whole sequence needs well under 300 cycles, so this only trips on a hang.
    initial begin
        repeat (2000) @(posedge i_ref_clk);
        fail_count++;
        report_and_stop;
    end
endmodule
bind pin_config_bank pin_config_bank_checker u_chk (.i_ref_clk(i_ref_clk), .i_rst(i_rst), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .o_pad_oe(o_pad_oe));
`default_nettype wire
